// file: hw/odsl_pkg.sv
package odsl_pkg;
    localparam int          ADDR_W     = 3;
    localparam int          VAL_W      = 8;
    localparam int          WORD_W     = ADDR_W + VAL_W;
    localparam int          NUM_CH     = 8;
    localparam logic [VAL_W-1:0] CH_RESET = 8'h00;
    localparam int          CLK_MHZ    = 125;
    localparam int          LINK_NS    = 160;
    localparam int          LINK_CYC   = LINK_NS * CLK_MHZ / 1000;
endpackage : odsl_pkg

// file: hw/odsl_port.sv
module odsl_port (
    input  wire logic                                CLK_I,
    input  wire logic                                SRST_I,
    input  wire logic                                SERIAL_CLK_I,
    input  wire logic                                SELECT_N_I,
    input  wire logic                                SERIAL_DATA_IN_I,
    output logic [odsl_pkg::NUM_CH*odsl_pkg::VAL_W-1:0] CH_VALUES_O,
    output logic                                     LOAD_O
);
    typedef struct packed {
        logic [1:0]                     sclk_sync;
        logic [1:0]                     sel_sync;
        logic [1:0]                     sdi_sync;
        logic                           sclk_prev;
        logic                           sel_prev;
        logic [odsl_pkg::WORD_W-1:0]    shift;
        logic [odsl_pkg::NUM_CH-1:0][odsl_pkg::VAL_W-1:0] ch;
        logic                           load;
    } odsl_state_t;

    odsl_state_t st_reg;
    odsl_state_t st_next;

    logic sclk_s;
    logic sel_s;
    logic sdi_s;
    logic sclk_rise;
    logic sel_rise;
    logic [odsl_pkg::ADDR_W-1:0] word_addr;
    logic [odsl_pkg::VAL_W-1:0]  word_val;

    // Only second stages are read; first stages feed nothing else
    assign sclk_s    = st_reg.sclk_sync[1];
    assign sel_s     = st_reg.sel_sync[1];
    assign sdi_s     = st_reg.sdi_sync[1];
    assign sclk_rise = sclk_s && !st_reg.sclk_prev;
    assign sel_rise  = sel_s && !st_reg.sel_prev;
    // Address leads the word, value trails it
    assign word_addr = st_reg.shift[odsl_pkg::WORD_W-1 -: odsl_pkg::ADDR_W];
    assign word_val  = st_reg.shift[odsl_pkg::VAL_W-1:0];

    always_comb begin
        st_next           = st_reg;
        st_next.sclk_sync = {st_reg.sclk_sync[0], SERIAL_CLK_I};
        st_next.sel_sync  = {st_reg.sel_sync[0], SELECT_N_I};
        st_next.sdi_sync  = {st_reg.sdi_sync[0], SERIAL_DATA_IN_I};
        st_next.sclk_prev = sclk_s;
        st_next.sel_prev  = sel_s;
        st_next.load      = 1'b0;
        // Data and clock share sync depth, so data is stable at the edge
        if (!sel_s && sclk_rise) begin
            // MSB first; oldest extra bits fall off the top
            st_next.shift = {st_reg.shift[odsl_pkg::WORD_W-2:0], sdi_s};
        end
        if (sel_rise) begin
            st_next.ch[word_addr] = word_val;
            st_next.load          = 1'b1;
        end
        if (SRST_I) begin
            st_next = '0;
            st_next.sclk_sync = '1;
            st_next.sel_sync  = '1;
            st_next.sclk_prev = 1'b1;
            st_next.sel_prev  = 1'b1;
            for (int i = 0; i < odsl_pkg::NUM_CH; i++) begin
                st_next.ch[i] = odsl_pkg::CH_RESET;
            end
        end
    end

    always_ff @(posedge CLK_I) begin
        st_reg <= st_next;
    end

    assign CH_VALUES_O = st_reg.ch;
    assign LOAD_O      = st_reg.load;

    AST_LOAD_ON_SELECT_RISE: assert property (@(posedge CLK_I) disable iff (SRST_I)
        sel_rise |=> LOAD_O && CH_VALUES_O[$past(word_addr)*odsl_pkg::VAL_W +: odsl_pkg::VAL_W]
            == $past(word_val))
        else $error("Addressed channel not loaded on select rise");
    AST_NO_CHANGE_WITHOUT_SELECT: assert property (@(posedge CLK_I) disable iff (SRST_I)
        !sel_rise |=> $stable(CH_VALUES_O) && !LOAD_O)
        else $error("Channel changed without select rise");
    AST_SHIFT_ON_CLOCK: assert property (@(posedge CLK_I) disable iff (SRST_I)
        (!sel_s && sclk_rise) |=> st_reg.shift[0] == $past(sdi_s))
        else $error("Data bit not sampled on clock rise");
    AST_SHIFT_HOLD: assert property (@(posedge CLK_I) disable iff (SRST_I)
        !(!sel_s && sclk_rise) |=> $stable(st_reg.shift))
        else $error("Shift register moved without clock rise");
    AST_MSB_LEADS: assert property (@(posedge CLK_I) disable iff (SRST_I)
        (!sel_s && sclk_rise) |=> st_reg.shift[odsl_pkg::WORD_W-1:1]
            == $past(st_reg.shift[odsl_pkg::WORD_W-2:0]))
        else $error("Earlier bits not moved toward address end");

    // Load is a lone pulse, so one frame can never update a channel twice
    sequence seq_frame_end;
        sel_rise;
    endsequence
    sequence seq_load_pulse;
        LOAD_O ##1 !LOAD_O;
    endsequence
    sequence seq_idle_clock;
        sel_s && sclk_rise;
    endsequence

    AST_LOAD_ONE_CYCLE: assert property (@(posedge CLK_I) disable iff (SRST_I)
        seq_frame_end |=> seq_load_pulse)
        else $error("Load strobe not a single cycle");
    AST_RESET_CLEARS: assert property (@(posedge CLK_I)
        SRST_I |=> (CH_VALUES_O == {odsl_pkg::NUM_CH{odsl_pkg::CH_RESET}}) && !LOAD_O)
        else $error("Channels not at reset value after reset");
    // Clock edges with select high must not disturb a half-built word
    AST_IDLE_CLOCK_IGNORED: assert property (@(posedge CLK_I) disable iff (SRST_I)
        seq_idle_clock |=> $stable(st_reg.shift))
        else $error("Shift register moved while select high");
endmodule : odsl_port

// file: test/odsl_host.sv
module odsl_host (
    input  wire logic clk_i,
    output logic      sclk_o,
    output logic      sel_n_o,
    output logic      sdi_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        sclk_o = 1'b1;
        sel_n_o = 1'b1;
        sdi_o = 1'b0;
    end
    // 10 cycles per level gives the 160 ns link period
    task automatic send(input int n, input logic [15:0] w);
        @(posedge clk_i);
        sel_n_o <= 1'b0;
        repeat (10) @(posedge clk_i);
        for (int i = n - 1; i >= 0; i--) begin
            sdi_o <= w[i];
            sclk_o <= 1'b0;
            repeat (10) @(posedge clk_i);
            sclk_o <= 1'b1;
            repeat (10) @(posedge clk_i);
        end
        sel_n_o <= 1'b1;
        sdi_o <= ~w[0];
    endtask : send
    // Clock pulses with select high; the port must ignore them
    task automatic idle_clk(input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clk_i);
            sdi_o <= 1'b1;
            sclk_o <= 1'b0;
            repeat (10) @(posedge clk_i);
            sclk_o <= 1'b1;
            repeat (9) @(posedge clk_i);
        end
    endtask : idle_clk
endmodule : odsl_host

// file: test/odsl_port_tb.sv
module odsl_port_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic        sclk, sel_n, serial_data_in, load;
    logic [63:0] chv;
    logic [7:0]  model [8] = '{default: 8'h00};
    int          fail_count = 0;
    int          n_checks = 0;
    always #4 clk = ~clk;
    odsl_port i_odsl_port (.CLK_I(clk), .SRST_I(srst), .SERIAL_CLK_I(sclk),
        .SELECT_N_I(sel_n), .SERIAL_DATA_IN_I(serial_data_in), .CH_VALUES_O(chv), .LOAD_O(load));
    odsl_host i_odsl_host (.clk_i(clk), .sclk_o(sclk), .sel_n_o(sel_n), .sdi_o(serial_data_in));
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp
    task automatic chk_all;
        for (int c = 0; c < 8; c++) cmp(chv[8*c +: 8], model[c]);
    endtask : chk_all
    task automatic load_chk(input int n, input logic [15:0] w);
        int k;
        i_odsl_host.send(n, w);
        chk_all();
        k = 0;
        while (load !== 1'b1 && k < 12) begin
            @(posedge clk);
            #1 k++;
        end
        cmp({7'h00, load}, 8'h01);
        @(posedge clk);
        #1 cmp({7'h00, load}, 8'h00);
        model[w[10:8]] = w[7:0];
        chk_all();
    endtask : load_chk
    task automatic t_channels;
        for (int c = 0; c < 8; c++) load_chk(11, {5'h00, 3'(c), 8'hA5 ^ 8'(c)});
        $display("t_channels done");
    endtask : t_channels
    task automatic t_pad;
        load_chk(16, 16'hF95A);
        load_chk(16, 16'h0E3C);
        $display("t_pad done");
    endtask : t_pad
    task automatic t_idle;
        i_odsl_host.idle_clk(4);
        load_chk(0, 16'h063C);
        $display("t_idle done");
    endtask : t_idle
    task automatic conclude;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : conclude
    initial begin
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        chk_all();
        t_channels();
        t_pad();
        t_idle();
        conclude();
    end
    // About 11 frames of under 3 us each, with margin
    initial begin
        #100000;
        fail_count++;
        conclude();
    end
endmodule : odsl_port_tb
